// ---- hw/dswseq_pkg.sv ----
// types shared by the deep-sleep wake sequencer
package dswseq_pkg;
    // sequencer states, one-hot
    typedef enum logic [5:0] {
        DSW_RUN = 6'h01,
        DSW_WAIT_IDLE = 6'h02,
        DSW_WAIT_ACC = 6'h04,
        DSW_SHORT = 6'h08,
        DSW_DEEP = 6'h10,
        DSW_WAKE = 6'h20
    } dswseq_state_t;
    // wake sources after debouncing
    typedef struct packed {
        logic ring;
        logic ext;
        logic sync;
        logic rst;
    } dswseq_wake_t;
endpackage : dswseq_pkg

// ---- hw/dswseq_regs.svh ----
// timing constants and field positions for the deep-sleep wake sequencer
`ifndef DSWSEQ_REGS_SVH
`define DSWSEQ_REGS_SVH
// power mode register field positions
`define DSWSEQ_MODE_SLEEP_BIT 0
`define DSWSEQ_MODE_SLOW_BIT 1
`define DSWSEQ_MODE_IGNORE_PWR_BIT 3
// sync-request wake comes from this port b line
`define DSWSEQ_SYNC_GPIO_BIT 10
// debounce tick: 250 Hz from the rtc source, filter length in ticks
`define DSWSEQ_DEB_TICKS 3
`endif

// ---- hw/dswseq_top.sv ----
// deep-sleep entry and wake sequencer
`timescale 1ns/1ps
`include "dswseq_regs.svh"
module dswseq_top
    import dswseq_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // slow debounce clock from the rtc source, sampled as a pin
    input wire logic deb_clk_250,
    // wake pins and events
    input wire logic ring_indicator_pin_n,
    input wire logic external_wake_n,
    input wire logic system_reset_n,
    input wire logic [15:0] general_io_port_b,
    input wire logic rtc_event,
    // power good inputs
    input wire logic adapter_power_good,
    input wire logic battery_power_good,
    // power mode register contents
    input wire logic [7:0] power_mode_register,
    // bus status
    input wire logic bus_idle,
    input wire logic bus_access,
    // interrupt masks (one per source: ring, ext, sync, rtc)
    input wire logic [3:0] wake_irq_mask,
    // outputs
    output logic bus_grant_pmu,
    output logic deep_sleep,
    output logic short_sleep,
    output logic wake_pulse,
    output logic [3:0] wake_irq
);
    // ************************************
    // input synchronisers
    // ************************************
    // three flops per pin; change taken when stages two and three agree
    logic [7:0] s1_r, s2_r, s3_r;
    logic [7:0] raw;
    logic [7:0] cln_r; // agreed value
    assign raw = {deb_clk_250, rtc_event, adapter_power_good, battery_power_good,
                  ~ring_indicator_pin_n, ~external_wake_n,
                  // sync source from port b line
                  general_io_port_b[`DSWSEQ_SYNC_GPIO_BIT], ~system_reset_n};
    // sample chain
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_r <= 8'h00;
            s2_r <= 8'h00;
            s3_r <= 8'h00;
            cln_r <= 8'h00;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // only bits whose stages agree update
            cln_r <= (cln_r & ~(s2_r ~^ s3_r)) | (s2_r & (s2_r ~^ s3_r));
        end
    end
    // ************************************
    // debounce on the 250 hz tick
    // ************************************
    logic tick_d_r; // previous tick level
    logic tick;
    assign tick = cln_r[7] & ~tick_d_r;
    always_ff @(posedge mclk) begin
        if (rst) begin
            tick_d_r <= 1'b0;
        end else begin
            tick_d_r <= cln_r[7];
        end
    end
    // per source counters: ring, ext, sync, rst
    logic [1:0] deb_cnt_r [4];
    logic [3:0] deb_r; // debounced levels
    // filter four sources, only on tick
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                deb_cnt_r[i] <= 2'h0;
            end
            deb_r <= 4'h0;
        end else if (tick) begin
            for (int i = 0; i < 4; i++) begin
                if (cln_r[i] == deb_r[i]) begin
                    deb_cnt_r[i] <= 2'h0;
                end else if (deb_cnt_r[i] == 2'(`DSWSEQ_DEB_TICKS - 1)) begin
                    deb_cnt_r[i] <= 2'h0;
                    deb_r[i] <= cln_r[i];
                end else begin
                    deb_cnt_r[i] <= deb_cnt_r[i] + 2'h1;
                end
            end
        end
    end
    // ************************************
    // wake decision
    // ************************************
    logic rtc_ev; // rtc not debounced
    logic any_wake;
    logic pwr_ok;
    assign rtc_ev = cln_r[6];
    // no mask in the wake path
    assign any_wake = |deb_r | rtc_ev;
    assign pwr_ok = cln_r[5] | cln_r[4] | power_mode_register[`DSWSEQ_MODE_IGNORE_PWR_BIT];
    logic sleep_req;
    assign sleep_req = power_mode_register[`DSWSEQ_MODE_SLEEP_BIT]
                       & power_mode_register[`DSWSEQ_MODE_SLOW_BIT];
    // ************************************
    // sequencer
    // ************************************
    dswseq_state_t st_r, st_nxt;
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            DSW_RUN: begin
                if (sleep_req && !any_wake) begin
                    st_nxt = DSW_WAIT_IDLE;
                end
            end
            DSW_WAIT_IDLE: begin
                if (any_wake || !sleep_req) begin
                    st_nxt = DSW_RUN;
                end else if (bus_idle) begin
                    st_nxt = DSW_WAIT_ACC;
                end
            end
            DSW_WAIT_ACC: begin
                if (any_wake || !sleep_req) begin
                    st_nxt = DSW_RUN;
                end else if (bus_access) begin
                    st_nxt = DSW_SHORT;
                end
            end
            DSW_SHORT: begin
                st_nxt = DSW_DEEP;
            end
            DSW_DEEP: begin
                if (any_wake && pwr_ok) begin
                    st_nxt = DSW_WAKE;
                end
            end
            DSW_WAKE: begin
                st_nxt = DSW_RUN;
            end
        endcase
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= DSW_RUN;
        end else begin
            st_r <= st_nxt;
        end
    end
    // ************************************
    // registered outputs
    // ************************************
    // grant drops on the wake step
    always_ff @(posedge mclk) begin
        if (rst) begin
            bus_grant_pmu <= 1'b0;
            deep_sleep <= 1'b0;
            short_sleep <= 1'b0;
            wake_pulse <= 1'b0;
        end else begin
            bus_grant_pmu <= (st_nxt == DSW_SHORT) || (st_nxt == DSW_DEEP);
            deep_sleep <= st_nxt == DSW_DEEP;
            short_sleep <= st_nxt == DSW_SHORT;
            wake_pulse <= st_nxt == DSW_WAKE;
        end
    end
    // debounced levels by source name, so the irq order cannot slip against the filter order
    dswseq_wake_t deb_src;
    assign deb_src = dswseq_wake_t'(deb_r);
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_irq <= 4'h0;
        end else begin
            wake_irq <= {deb_src.ring, deb_src.ext, deb_src.sync, rtc_ev} & ~wake_irq_mask;
        end
    end
    // ************************************
    // checks
    // ************************************
    sequence entry_s;
        st_r == DSW_WAIT_ACC && bus_access && sleep_req && !any_wake;
    endsequence
    no_wake_nopwr_a: assert property (@(posedge mclk) disable iff (rst)
        (st_r == DSW_DEEP && !pwr_ok) |=> st_r == DSW_DEEP)
        else $error("wake without power");
    wake_fires_a: assert property (@(posedge mclk) disable iff (rst)
        (st_r == DSW_DEEP && any_wake && pwr_ok) |=> st_r == DSW_WAKE ##1 st_r == DSW_RUN)
        else $error("wake not taken");
    mask_no_wake_a: assert property (@(posedge mclk) disable iff (rst)
        (st_r == DSW_DEEP && rtc_ev && pwr_ok) |=> wake_pulse)
        else $error("rtc wake lost");
    // a masked source never shows on the interrupt outputs
    irq_mask_gate_a: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> (wake_irq & $past(wake_irq_mask)) == 4'h0)
        else $error("masked source raised irq");
    block_entry_a: assert property (@(posedge mclk) disable iff (rst)
        (st_r == DSW_RUN && any_wake) |=> st_r == DSW_RUN)
        else $error("entry with wake pending");
    idle_wait_a: assert property (@(posedge mclk) disable iff (rst)
        (st_r == DSW_WAIT_IDLE && !bus_idle) |=> st_r != DSW_WAIT_ACC)
        else $error("left before idle");
    take_bus_a: assert property (@(posedge mclk) disable iff (rst)
        entry_s |=> st_r == DSW_SHORT ##1 (st_r == DSW_DEEP && bus_grant_pmu && deep_sleep))
        else $error("entry sequence wrong");
    release_bus_a: assert property (@(posedge mclk) disable iff (rst)
        (st_r == DSW_WAKE) |-> !bus_grant_pmu && wake_pulse)
        else $error("bus kept on wake");
    deb_tick_a: assert property (@(posedge mclk) disable iff (rst)
        !tick |=> $stable(deb_r))
        else $error("debounce moved off tick");
    override_a: assert property (@(posedge mclk) disable iff (rst)
        (st_r == DSW_DEEP && any_wake && power_mode_register[`DSWSEQ_MODE_IGNORE_PWR_BIT])
        |=> st_r == DSW_WAKE)
        else $error("override ignored");
endmodule : dswseq_top

// ---- test/dswseq_partner.sv ----
// far-side model: rtc-derived debounce clock and cpu bus activity
`timescale 1ns/1ps
module dswseq_partner #(
    // scaled half period of the 250 Hz tick, in mclk cycles, keeps the run short
    parameter int TICK_HALF = 10
) (
    // clock and rtc oscillator control
    input wire logic mclk,
    input wire logic rtc_run,
    // toward the sequencer
    output logic deb_clk_250 = 1'b0,
    output logic bus_idle = 1'b0,
    output logic bus_access = 1'b0
);
    int tick_cnt = 0; // rtc divider count
    logic [7:0] acc_cnt = 8'h00; // cpu activity phase
    // stopped oscillator
    // divider freezes while the oscillator is stopped, so no tick reaches the filter
    always @(posedge mclk) begin
        if (rtc_run) begin
            tick_cnt <= (tick_cnt == TICK_HALF - 1) ? 0 : tick_cnt + 1;
            if (tick_cnt == TICK_HALF - 1) begin
                deb_clk_250 <= ~deb_clk_250;
            end
        end
    end
    // loop then read
    // dummy loop leaves the bus idle half the time; a single read every 16 cycles
    always @(posedge mclk) begin
        acc_cnt <= acc_cnt + 8'h01;
        bus_idle <= acc_cnt[5];
        bus_access <= (acc_cnt[3:0] == 4'hf);
    end
endmodule : dswseq_partner

// ---- test/dswseq_top_test.sv ----
// self-checking bench for the deep-sleep wake sequencer
`timescale 1ns/1ps
module dswseq_top_test;
    // ****************
    // stimulus and observed signals
    // ****************
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic rtc_run = 1'b1; // rtc oscillator running
    logic ring_indicator_pin_n = 1'b1;
    logic external_wake_n = 1'b1;
    logic system_reset_n = 1'b1;
    logic [15:0] general_io_port_b = 16'h0000;
    logic rtc_event = 1'b0;
    logic adapter_power_good = 1'b1;
    logic battery_power_good = 1'b0;
    logic [7:0] power_mode_register = 8'h00;
    logic [3:0] wake_irq_mask = 4'h0;
    logic deb_clk_250, bus_idle, bus_access, bus_grant_pmu, deep_sleep, short_sleep, wake_pulse;
    logic [3:0] wake_irq;
    logic [3:0] irq_of [5] = '{4'h8, 4'h4, 4'h2, 4'h0, 4'h1}; // irq bit of each source
    logic [7:0] exp_q [$]; // expected {grant, deep, irq} at each wake
    int n_mismatch = 0;
    int check_count = 0;
    int s;
    logic [3:0] m;
    initial begin
        forever #50 mclk = ~mclk;
    end
    dswseq_partner peer_u (.mclk, .rtc_run, .deb_clk_250, .bus_idle, .bus_access);
    dswseq_top dut_u (.mclk, .rst, .deb_clk_250, .ring_indicator_pin_n, .external_wake_n,
        .system_reset_n, .general_io_port_b, .rtc_event, .adapter_power_good,
        .battery_power_good, .power_mode_register, .bus_idle, .bus_access, .wake_irq_mask,
        .bus_grant_pmu, .deep_sleep, .short_sleep, .wake_pulse, .wake_irq);
    // ****************
    // tasks
    // ****************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // wake source asserted
    // one source active, other port b lines random; bit 10 only when chosen
    task automatic set_src(input int src, input logic on);
        ring_indicator_pin_n <= !(on && src == 0);
        external_wake_n <= !(on && src == 1);
        general_io_port_b <= {5'($urandom), on && src == 2, 10'($urandom)};
        system_reset_n <= !(on && src == 3);
        rtc_event <= on && src == 4;
    endtask : set_src
    task automatic enter_sleep(input logic [7:0] mode);
        int i;
        power_mode_register <= mode;
        for (i = 0; i < 600 && short_sleep !== 1'b1; i++) @(posedge mclk);
        chk({7'h0, short_sleep}, 8'h01);
        @(posedge mclk);
        chk({6'h0, bus_grant_pmu, deep_sleep}, 8'h03);
        power_mode_register <= mode & 8'hfe;
    endtask : enter_sleep
    task automatic wait_wake;
        int i;
        for (i = 0; i < 400 && deep_sleep !== 1'b0; i++) @(posedge mclk);
        chk({7'h0, deep_sleep}, 8'h00);
    endtask : wait_wake
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    // every wake pulse takes the oldest note; a stray wake finds none and fails
    always @(posedge mclk) begin
        if (!rst && wake_pulse === 1'b1) begin
            chk({bus_grant_pmu, deep_sleep, 2'b00, wake_irq}, exp_q.size() ? exp_q.pop_front() : 8'hee);
        end
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        void'($urandom(56));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        // each source wakes, either power good input suffices, masks random
        for (s = 0; s < 5; s++) begin
            enter_sleep(8'h03);
            m = 4'($urandom);
            wake_irq_mask <= m;
            adapter_power_good <= s[0];
            battery_power_good <= !s[0];
            exp_q.push_back({4'h0, irq_of[s] & ~m});
            set_src(s, 1'b1);
            wait_wake();
            set_src(s, 1'b0);
            repeat (100) @(posedge mclk);
            $display("wake source %0d done", s);
        end
        // no power good holds it asleep until the override bit
        enter_sleep(8'h03);
        adapter_power_good <= 1'b0;
        battery_power_good <= 1'b0;
        set_src(1, 1'b1);
        repeat (200) @(posedge mclk);
        chk({7'h0, deep_sleep}, 8'h01);
        exp_q.push_back({4'h0, 4'h4 & ~m});
        power_mode_register <= 8'h0a;
        wait_wake();
        set_src(1, 1'b0);
        adapter_power_good <= 1'b1;
        repeat (100) @(posedge mclk);
        $display("power check done");
        // stopped rtc oscillator blocks a debounced wake
        enter_sleep(8'h03);
        rtc_run <= 1'b0;
        set_src(0, 1'b1);
        repeat (200) @(posedge mclk);
        chk({7'h0, deep_sleep}, 8'h01);
        exp_q.push_back({4'h0, 4'h8 & ~m});
        rtc_run <= 1'b1;
        wait_wake();
        $display("rtc stop test done");
        // entry refused while a wake pin is held
        power_mode_register <= 8'h03;
        repeat (200) @(posedge mclk);
        chk({6'h0, bus_grant_pmu, deep_sleep}, 8'h00);
        set_src(0, 1'b0);
        enter_sleep(8'h03);
        chk(8'(exp_q.size()), 8'h00);
        $display("refusal test done");
        summarize();
    end
    // hang guard, far beyond the expected few thousand cycles
    initial begin
        #3ms;
        n_mismatch++;
        summarize();
    end
endmodule : dswseq_top_test
